// *** hw/esr_pkg.sv ***
`default_nettype none
package esr_pkg;
	// widths of the config command port and the virtual wire groups
	localparam int CFG_AW = 16;
	localparam int IDX_W = 8;
	localparam int VW_W = 4;
	localparam int SLP_W = 3;
	localparam int N_UP = 3;
	// config locations
	localparam logic [15:0] LOC_DEV_ID = 16'h0004;
	localparam logic [15:0] LOC_GEN = 16'h0008;
	localparam logic [15:0] LOC_CH0 = 16'h0010;
	localparam logic [15:0] LOC_CH1 = 16'h0020;
	// virtual wire indexes
	localparam logic [7:0] IDX_SLP = 8'h02;
	localparam logic [7:0] IDX_BOOT = 8'h05;
	localparam logic [7:0] IDX_HOST = 8'h06;
	localparam logic [7:0] IDX_HRW = 8'h07;
	localparam logic [7:0] IDX_SACK = 8'h40;
	localparam logic [7:0] IDX_SWARN = 8'h41;
	// bit positions inside a group
	localparam int BIT_BOOT_DONE = 0;
	localparam int BIT_BOOT_STAT = 3;
	localparam int BIT_HRA = 3;
	localparam int BIT_HRW = 0;
	localparam int BIT_SACK = 0;
	localparam int BIT_SWARN = 0;
	localparam int BIT_SPA = 1;
	// wire group defaults
	localparam logic [2:0] SLP_RST = 3'h0;
	localparam logic [3:0] UP5_RST = 4'h0;
	localparam logic [3:0] UP6_RST = 4'h7;
	localparam logic [3:0] UP40_RST = 4'h0;
	// pending slots of the upstream sender
	localparam int SLOT_BOOT = 0;
	localparam int SLOT_HOST = 1;
	localparam int SLOT_SACK = 2;
	// config register layouts
	localparam logic [31:0] GEN_RW_MASK = 32'hDCF0F000;
	localparam logic [31:0] GEN_RO_VAL = 32'h030C0003;
	localparam logic [31:0] CH0_RW_MASK = 32'h00007705;
	localparam logic [31:0] CH0_RST = 32'h00001101;
	localparam logic [31:0] CH0_RO_VAL = 32'h00000010;
	localparam logic [31:0] CH1_RW_MASK = 32'h003F0001;
	localparam logic [31:0] CH1_RST = 32'h00000000;
	localparam logic [31:0] CH1_RO_VAL = 32'h00003F00;
	localparam int BIT_EN = 0;
	localparam int BIT_RDY = 1;
	// synchroniser lanes
	localparam int N_SYNC = 7;
	localparam int S_ROLE = 0;
	localparam int S_SACK = 1;
	localparam int S_HALT = 2;
	localparam int S_GRANT = 3;
	localparam int S_LCLK = 4;
	localparam int S_ERST = 5;
	localparam int S_PRST = 6;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_SEND = 2'h2
	} esr_state_t;
endpackage
`default_nettype wire

// *** hw/esr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module esr_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_q;

	// two stages; only the second stage is visible outside
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			q_out <= '0;
		end else begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** hw/esr_role_ctrl.sv ***
// Summary of operation
// - role pin level steers the role continuously, never latched once
// - high role: ack pin shows suspend-powerdown ack; host reset ack sent up
// - primary sends boot-load done and status bits of index 5h as one
// - low role: no boot-load wires, suspend-ack pin ignored
// - secondary answers no wire handshake; downstream wires only recorded
// - secondary: ack pin shows host-reset acknowledge
// - secondary never sends host-reset acknowledge upstream
// - host-reset ack rises after warn rise once lpc is halted
// - low then high role: boot-load wires sent at the rise
// - delayed start: pin first host-reset ack low, then powerdown ack
// - suspend-warning pin follows downstream suspend-warn wire
// - each suspend-ack pin edge in the primary role queues an index 40h update
// - each index carries four bits with one fixed direction
// - index 2h sleep bits default zero, cleared by espi reset
// - index 5h bits default zero, cleared by espi reset
// - index 6h default 0111, restored by platform reset
// - peripheral side offers no bus mastering, ltr or dma
// - runs up to 50 MHz; frequency field stored, never enforced
// - config registers reached only by get and set config commands
// - espi reset also resets the platform reset domain
`timescale 1ns/1ps
`default_nettype none
module esr_role_ctrl #(
	parameter logic [7:0] VERSION_ID = 8'hA5 // arbitrary value
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic espi_rstn_in,
	input wire logic plt_rstn_in,
	input wire logic espi_clk_in,
	input wire logic role_select_in,
	input wire logic suspend_acknowledge_pin_n_in,
	input wire logic lpc_halted_in,
	input wire logic vw_dn_valid_in,
	input wire logic [esr_pkg::IDX_W-1:0] vw_dn_index_in,
	input wire logic [esr_pkg::VW_W-1:0] vw_dn_data_in,
	input wire logic vw_up_grant_in,
	output logic vw_up_valid_out,
	output logic [esr_pkg::IDX_W-1:0] vw_up_index_out,
	output logic [esr_pkg::VW_W-1:0] vw_up_data_out,
	input wire logic cfg_req_in,
	input wire logic cfg_wr_in,
	input wire logic [esr_pkg::CFG_AW-1:0] cfg_loc_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic cfg_ack_out,
	output logic [31:0] cfg_rdata_out,
	output logic suspend_warning_pin_n_out,
	output logic multiplexed_acknowledge_pin_out,
	output logic [esr_pkg::SLP_W-1:0] sleep_state_out
);
	import esr_pkg::*;

	logic rst_meta_q, rst_n;
	logic [N_SYNC-1:0] sync_s;
	logic primary, sa_s, halted_s, grant_s, lclk_s, esp_clr, plt_clr;
	logic role_prev_q, sa_prev_q, lclk_prev_q;
	logic [SLP_W-1:0] slp_q;
	logic swarn_q, spa_q, hrw_q, hra_pend_q, hra_q, boot_sent_q;
	logic [VW_W-1:0] up5_q, up6_q, up40_q;
	logic [N_UP-1:0] pend_q, pend_set, pend_clr, dom_clr, out_sel_q;
	logic [IDX_W-1:0] out_idx_q;
	logic [VW_W-1:0] out_data_q;
	esr_state_t state_q, state_d;
	logic [31:0] gen_q, ch0_q, ch1_q, rdata_q;
	logic ack_q, mux_q;

	// top reset: asserted at once, released through two flops
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_q <= 1'h0;
			rst_n <= 1'h0;
		end else begin
			rst_meta_q <= 1'h1;
			rst_n <= rst_meta_q;
		end
	end

	// every pin and the link clock cross into ref_clk here
	esr_sync #(.W(N_SYNC)) u_sync (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n),
		.d_in({plt_rstn_in, espi_rstn_in, espi_clk_in, vw_up_grant_in,
			lpc_halted_in, suspend_acknowledge_pin_n_in, role_select_in}),
		.q_out(sync_s)
	);

	// role straight from the synced pin level, no capture
	assign primary = sync_s[S_ROLE];
	assign sa_s = sync_s[S_SACK];
	assign halted_s = sync_s[S_HALT];
	assign grant_s = sync_s[S_GRANT];
	assign lclk_s = sync_s[S_LCLK];
	// reset domains; espi reset drags the platform domain along
	assign esp_clr = ~sync_s[S_ERST];
	assign plt_clr = esp_clr | ~sync_s[S_PRST];

	// edge history; the suspend-ack copy parks at the pin's idle high level
	// while the espi domain is held, so its release shows no false edge
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			role_prev_q <= 1'h0;
			sa_prev_q <= 1'h1;
			lclk_prev_q <= 1'h0;
		end else begin
			role_prev_q <= primary;
			sa_prev_q <= esp_clr ? 1'h1 : sa_s;
			lclk_prev_q <= lclk_s;
		end
	end

	logic role_rise, sa_edge, lclk_rise;
	assign role_rise = primary & ~role_prev_q;
	assign sa_edge = (sa_s ^ sa_prev_q) & ~esp_clr;
	assign lclk_rise = lclk_s & ~lclk_prev_q;

	// downstream group decode: index picks a four bit group
	logic dn_slp_wr, dn_hrw_wr, dn_swarn_wr, hrw_rise;
	assign dn_slp_wr = vw_dn_valid_in & (vw_dn_index_in == IDX_SLP);
	assign dn_hrw_wr = vw_dn_valid_in & (vw_dn_index_in == IDX_HRW);
	assign dn_swarn_wr = vw_dn_valid_in & (vw_dn_index_in == IDX_SWARN);
	assign hrw_rise = dn_hrw_wr & vw_dn_data_in[BIT_HRW] & ~hrw_q;

	// espi-domain downstream wires, kept in either role
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			slp_q <= SLP_RST;
			swarn_q <= 1'h0;
			spa_q <= 1'h0;
		end else if (esp_clr) begin
			slp_q <= SLP_RST;
			swarn_q <= 1'h0;
			spa_q <= 1'h0;
		end else begin
			if (dn_slp_wr)
				slp_q <= vw_dn_data_in[SLP_W-1:0];
			if (dn_swarn_wr) begin
				swarn_q <= vw_dn_data_in[BIT_SWARN];
				spa_q <= vw_dn_data_in[BIT_SPA];
			end
		end
	end

	// host reset warn and ack live in the platform domain
	// ack waits for the lpc side to report a graceful halt
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			hrw_q <= 1'h0;
			hra_pend_q <= 1'h0;
			hra_q <= 1'h0;
		end else if (plt_clr) begin
			hrw_q <= 1'h0;
			hra_pend_q <= 1'h0;
			hra_q <= 1'h0;
		end else begin
			if (dn_hrw_wr)
				hrw_q <= vw_dn_data_in[BIT_HRW];
			if (hrw_rise)
				hra_pend_q <= 1'h1;
			else if (hra_pend_q && halted_s)
				hra_pend_q <= 1'h0;
			if (hra_pend_q && halted_s)
				hra_q <= 1'h1;
			else if (dn_hrw_wr && !vw_dn_data_in[BIT_HRW])
				hra_q <= 1'h0;
		end
	end

	// legacy pins; the shared pin is switched live by the role
	assign suspend_warning_pin_n_out = swarn_q;
	// shared pin re-selected every cycle; a flop keeps mux glitches off it
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			mux_q <= 1'h0;
		else
			mux_q <= primary ? spa_q : hra_q;
	end
	assign multiplexed_acknowledge_pin_out = mux_q;
	assign sleep_state_out = slp_q;

	// upstream events; every one is gated by the primary role
	logic boot_set, host_set, sack_set;
	assign boot_set = primary & ~boot_sent_q & ~esp_clr;
	assign host_set = primary & (hra_q != up6_q[BIT_HRA]) & ~plt_clr;
	assign sack_set = primary & sa_edge;

	// boot-load wires go out once; a low role holds them back
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			boot_sent_q <= 1'h0;
			up5_q <= UP5_RST;
			up40_q <= UP40_RST;
		end else if (esp_clr) begin
			boot_sent_q <= 1'h0;
			up5_q <= UP5_RST;
			up40_q <= UP40_RST;
		end else begin
			if (boot_set) begin
				boot_sent_q <= 1'h1;
				up5_q[BIT_BOOT_DONE] <= 1'h1;
				up5_q[BIT_BOOT_STAT] <= 1'h1;
			end
			if (sack_set)
				up40_q[BIT_SACK] <= sa_s;
		end
	end

	// index 6h mirrors the internal ack only while primary
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			up6_q <= UP6_RST;
		else if (plt_clr)
			up6_q <= UP6_RST;
		else if (host_set)
			up6_q[BIT_HRA] <= hra_q;
	end

	// one pending flag per upstream group; a new event beats the clear
	logic sent;
	assign pend_set = {sack_set, host_set, boot_set};
	assign dom_clr = {esp_clr, plt_clr, esp_clr};
	assign sent = (state_q == ST_SEND) & grant_s & lclk_rise;
	assign pend_clr = sent ? out_sel_q : '0;
	genvar gi;
	generate
		for (gi = 0; gi < N_UP; gi++) begin : g_pend
			always_ff @(posedge ref_clk_in or negedge rst_n) begin
				if (!rst_n)
					pend_q[gi] <= 1'h0;
				else if (dom_clr[gi])
					pend_q[gi] <= 1'h0;
				else
					pend_q[gi] <= (pend_q[gi] & ~pend_clr[gi]) | pend_set[gi];
			end
		end
	endgenerate

	// fixed priority: boot first, then host reset ack, then suspend ack
	logic [N_UP-1:0] pick;
	logic [IDX_W-1:0] pick_idx;
	logic [VW_W-1:0] pick_data;
	logic can_load;
	assign pick[SLOT_BOOT] = pend_q[SLOT_BOOT];
	assign pick[SLOT_HOST] = pend_q[SLOT_HOST] & ~pend_q[SLOT_BOOT];
	assign pick[SLOT_SACK] = pend_q[SLOT_SACK] & ~pend_q[SLOT_BOOT]
		& ~pend_q[SLOT_HOST];
	assign pick_idx = pick[SLOT_BOOT] ? IDX_BOOT :
		pick[SLOT_HOST] ? IDX_HOST : IDX_SACK;
	assign pick_data = pick[SLOT_BOOT] ? up5_q :
		pick[SLOT_HOST] ? up6_q : up40_q;
	assign can_load = (|pend_q) & primary;

	// sender: offer a group, hand it over on a grant at a link clock rise
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (can_load)
					state_d = ST_SEND;
			end
			ST_SEND: begin
				if (sent)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else if (esp_clr)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// the offered group is frozen while it waits for the master
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			out_sel_q <= '0;
			out_idx_q <= '0;
			out_data_q <= '0;
		end else if (state_q == ST_IDLE && can_load) begin
			out_sel_q <= pick;
			out_idx_q <= pick_idx;
			out_data_q <= pick_data;
		end
	end

	assign vw_up_valid_out = (state_q == ST_SEND);
	assign vw_up_index_out = out_idx_q;
	assign vw_up_data_out = out_data_q;

	// config command decode; no memory or io path reaches these
	logic hit_id, hit_gen, hit_ch0, hit_ch1, cfg_wr, cfg_rd;
	logic [31:0] rd_mux, ch0_view, ch1_view;
	assign hit_id = (cfg_loc_in == LOC_DEV_ID);
	assign hit_gen = (cfg_loc_in == LOC_GEN);
	assign hit_ch0 = (cfg_loc_in == LOC_CH0);
	assign hit_ch1 = (cfg_loc_in == LOC_CH1);
	assign cfg_wr = cfg_req_in & cfg_wr_in;
	assign cfg_rd = cfg_req_in & ~cfg_wr_in;
	// ready bits mirror their enable bits
	assign ch0_view = ch0_q | CH0_RO_VAL
		| ({31'h0, ch0_q[BIT_EN]} << BIT_RDY);
	assign ch1_view = ch1_q | CH1_RO_VAL
		| ({31'h0, ch1_q[BIT_EN]} << BIT_RDY);
	assign rd_mux = hit_id ? {24'h0, VERSION_ID} :
		hit_gen ? (gen_q | GEN_RO_VAL) :
		hit_ch0 ? ch0_view :
		hit_ch1 ? ch1_view : 32'h0;

	// frequency select is only stored; nothing here limits the clock
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			gen_q <= 32'h0;
			ch1_q <= CH1_RST;
		end else if (esp_clr) begin
			gen_q <= 32'h0;
			ch1_q <= CH1_RST;
		end else if (cfg_wr) begin
			if (hit_gen)
				gen_q <= cfg_wdata_in & GEN_RW_MASK;
			else if (hit_ch1)
				ch1_q <= cfg_wdata_in & CH1_RW_MASK;
		end
	end

	// bus master enable is storage only; no mastering engine exists
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n)
			ch0_q <= CH0_RST;
		else if (plt_clr)
			ch0_q <= CH0_RST;
		else if (cfg_wr && hit_ch0)
			ch0_q <= cfg_wdata_in & CH0_RW_MASK;
	end

	// every command is answered one cycle later; unknown locations read 0
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'h0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= cfg_req_in;
			if (cfg_rd)
				rdata_q <= rd_mux;
		end
	end

	assign cfg_ack_out = ack_q;
	assign cfg_rdata_out = rdata_q;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n);

	a_boot_values: assert property (vw_up_valid_out
		&& out_idx_q == IDX_BOOT
		|-> out_data_q[BIT_BOOT_DONE] && out_data_q[BIT_BOOT_STAT])
		else $error("boot-load group sent without both bits set");
	a_boot_withheld: assert property (!primary && !role_prev_q
		|-> !pend_set[SLOT_BOOT])
		else $error("boot-load wires queued in secondary role");
	a_no_vw_answer: assert property (sent |-> primary)
		else $error("upstream wire sent while secondary");
	a_no_host_ack: assert property (!primary |-> !host_set
		&& !(sent && out_idx_q == IDX_HOST))
		else $error("host reset ack sent while secondary");
	a_ack_after_halt: assert property ($rose(hra_q) && !plt_clr
		|-> $past(hra_pend_q) && $past(halted_s))
		else $error("host reset ack rose before halt");
	a_pin_mux: assert property (!primary && $rose(hra_q)
		&& !plt_clr |=> multiplexed_acknowledge_pin_out)
		else $error("shared pin not showing host reset ack");
	a_warn_follow: assert property (dn_swarn_wr && !esp_clr
		|=> suspend_warning_pin_n_out == $past(vw_dn_data_in[BIT_SWARN]))
		else $error("suspend warning pin missed its wire");
	a_sack_update: assert property (primary && sa_edge
		|=> pend_q[SLOT_SACK] || esp_clr)
		else $error("suspend ack edge not queued upstream");
	a_boot_on_rise: assert property (role_rise && !esp_clr
		|-> ##[1:2] (pend_q[SLOT_BOOT] || boot_sent_q))
		else $error("role rise did not queue boot-load wires");
	a_plt_default: assert property (esp_clr |=> up6_q == UP6_RST)
		else $error("espi reset missed platform domain");
	a_cfg_answer: assert property (cfg_req_in |=> cfg_ack_out)
		else $error("config command not answered");

	c_boot_sent: cover property (sent && out_idx_q == IDX_BOOT);
	c_sack_sent: cover property (sent && out_idx_q == IDX_SACK);
	c_host_ack: cover property (!primary ##1 $rose(hra_q));
	c_late_role: cover property (role_rise ##[1:20] pend_q[SLOT_BOOT]);
endmodule
`default_nettype wire

// *** sim/esr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module esr_host_model (
	input wire logic ref_clk_in,
	input wire logic [7:0] delay_in,
	input wire logic vw_up_valid_in,
	input wire logic [esr_pkg::IDX_W-1:0] vw_up_index_in,
	input wire logic [esr_pkg::VW_W-1:0] vw_up_data_in,
	output logic espi_clk_out,
	output logic vw_up_grant_out,
	output logic [15:0] count_out,
	output logic [esr_pkg::IDX_W-1:0] idx_out,
	output logic [esr_pkg::VW_W-1:0] data_out
);
	import esr_pkg::*;
	// one grant and one link clock pulse per offered group; the clock
	// stands low between frames; rises at least 850 ns apart stay well under 50 MHz
	initial begin
		espi_clk_out = 1'b0;
		vw_up_grant_out = 1'b0;
		count_out = 16'h0000;
		idx_out = 8'h00;
		data_out = 4'h0;
		forever begin
			@(posedge ref_clk_in);
			if (vw_up_valid_in === 1'b1) begin
				repeat (delay_in) @(posedge ref_clk_in); // slow answer
				vw_up_grant_out <= 1'b1;
				repeat (4) @(posedge ref_clk_in);
				idx_out <= vw_up_index_in;
				data_out <= vw_up_data_in;
				espi_clk_out <= 1'b1;
				repeat (4) @(posedge ref_clk_in);
				espi_clk_out <= 1'b0;
				repeat (4) @(posedge ref_clk_in);
				vw_up_grant_out <= 1'b0;
				count_out <= count_out + 16'h0001;
				repeat (4) @(posedge ref_clk_in);
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import esr_pkg::*;
	localparam logic [7:0] VER = 8'h3C; // arbitrary value
	logic ref_clk, rstn, espi_rstn, plt_rstn, role, sack_n, halted;
	logic dn_valid, cfg_req, cfg_wr;
	logic [7:0] dn_idx, host_delay;
	logic [3:0] dn_data;
	logic [15:0] cfg_loc;
	logic [31:0] cfg_wdata;
	wire logic espi_clk, grant, up_valid, cfg_ack, warn_n, mux_ack;
	wire logic [7:0] up_idx, host_idx;
	wire logic [3:0] up_data, host_data;
	wire logic [31:0] cfg_rdata;
	wire logic [2:0] sleep;
	wire logic [15:0] host_count;
	int mismatches, total_checks;

	esr_role_ctrl #(.VERSION_ID(VER)) i_esr_role_ctrl (
		.ref_clk_in(ref_clk), .rstn_in(rstn), .espi_rstn_in(espi_rstn),
		.plt_rstn_in(plt_rstn), .espi_clk_in(espi_clk),
		.role_select_in(role), .suspend_acknowledge_pin_n_in(sack_n),
		.lpc_halted_in(halted), .vw_dn_valid_in(dn_valid),
		.vw_dn_index_in(dn_idx), .vw_dn_data_in(dn_data),
		.vw_up_grant_in(grant), .vw_up_valid_out(up_valid),
		.vw_up_index_out(up_idx), .vw_up_data_out(up_data),
		.cfg_req_in(cfg_req), .cfg_wr_in(cfg_wr), .cfg_loc_in(cfg_loc),
		.cfg_wdata_in(cfg_wdata), .cfg_ack_out(cfg_ack),
		.cfg_rdata_out(cfg_rdata), .suspend_warning_pin_n_out(warn_n),
		.multiplexed_acknowledge_pin_out(mux_ack),
		.sleep_state_out(sleep));

	esr_host_model i_esr_host_model (
		.ref_clk_in(ref_clk), .delay_in(host_delay),
		.vw_up_valid_in(up_valid), .vw_up_index_in(up_idx),
		.vw_up_data_in(up_data), .espi_clk_out(espi_clk),
		.vw_up_grant_out(grant), .count_out(host_count),
		.idx_out(host_idx), .data_out(host_data));

	// 20 MHz system clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one downstream group, outputs settle a cycle later
	task automatic dn(input logic [7:0] idx, input logic [3:0] d);
		@(posedge ref_clk);
		dn_valid <= 1'b1;
		dn_idx <= idx;
		dn_data <= d;
		@(posedge ref_clk);
		dn_valid <= 1'b0;
		tick(2);
		#1;
	endtask

	task automatic cfg(input logic wr, input logic [15:0] loc,
			input logic [31:0] wd, input logic [31:0] exp);
		@(posedge ref_clk);
		cfg_req <= 1'b1;
		cfg_wr <= wr;
		cfg_loc <= loc;
		cfg_wdata <= wd;
		@(posedge ref_clk);
		cfg_req <= 1'b0;
		#1;
		check({31'h0, cfg_ack}, 32'h1);
		if (!wr) check(cfg_rdata, exp);
	endtask

	// next group taken by the host, bounded wait
	task automatic up(input logic [7:0] idx, input logic [3:0] d);
		logic [15:0] start;
		int i;
		start = host_count;
		for (i = 0; i < 400 && host_count === start; i++) @(posedge ref_clk);
		check({16'h0, host_count}, {16'h0, start + 16'h0001});
		check({24'h0, host_idx}, {24'h0, idx});
		check({28'h0, host_data}, {28'h0, d});
	endtask

	// nothing may be sent upstream for n cycles
	task automatic quiet(input int n);
		logic [15:0] start;
		start = host_count;
		tick(n);
		check({16'h0, host_count}, {16'h0, start});
	endtask

	task automatic t_config;
		cfg(1'b0, LOC_DEV_ID, 32'h0, {24'h0, VER});
		cfg(1'b1, LOC_DEV_ID, 32'hFFFFFFFF, 32'h0);
		cfg(1'b0, LOC_DEV_ID, 32'h0, {24'h0, VER});
		cfg(1'b0, LOC_GEN, 32'h0, 32'h030C0003);
		cfg(1'b1, LOC_GEN, 32'hFFFFFFFF, 32'h0);
		cfg(1'b0, LOC_GEN, 32'h0, 32'hDFFCF003);
		cfg(1'b0, LOC_CH0, 32'h0, 32'h00001113);
		cfg(1'b1, LOC_CH0, 32'h0, 32'h0);
		cfg(1'b0, LOC_CH0, 32'h0, 32'h00000010);
		cfg(1'b0, LOC_CH1, 32'h0, 32'h00003F00);
		cfg(1'b1, LOC_CH1, 32'hFFFFFFFF, 32'h0);
		cfg(1'b0, LOC_CH1, 32'h0, 32'h003F3F03);
		cfg(1'b1, 16'h0030, 32'hFFFFFFFF, 32'h0);
		cfg(1'b0, 16'h0030, 32'h0, 32'h0);
	endtask

	task automatic t_secondary;
		check({31'h0, mux_ack}, 32'h0);
		dn(IDX_SWARN, 4'h2);
		check({31'h0, mux_ack}, 32'h0);
		check({31'h0, warn_n}, 32'h0);
		dn(IDX_SWARN, 4'h1);
		check({31'h0, warn_n}, 32'h1);
		sack_n <= 1'b0;
		quiet(60);
		sack_n <= 1'b1;
		quiet(60);
		dn(IDX_HRW, 4'h1);
		tick(30);
		check({31'h0, mux_ack}, 32'h0);
		halted <= 1'b1;
		tick(8);
		check({31'h0, mux_ack}, 32'h1);
		quiet(60);
		dn(IDX_HRW, 4'h0);
		check({31'h0, mux_ack}, 32'h0);
		dn(IDX_SLP, 4'h5);
		check({29'h0, sleep}, 32'h5);
		quiet(20);
	endtask

	task automatic t_delayed_start;
		host_delay <= 8'd40;
		role <= 1'b1;
		up(IDX_BOOT, 4'h9);
		tick(1);
		check({31'h0, mux_ack}, 32'h0);
		host_delay <= 8'd0;
		dn(IDX_SWARN, 4'h2);
		check({31'h0, mux_ack}, 32'h1);
		dn(IDX_SWARN, 4'h0);
		check({31'h0, mux_ack}, 32'h0);
	endtask

	task automatic t_primary;
		dn(IDX_HRW, 4'h1);
		up(IDX_HOST, 4'hF);
		check({31'h0, mux_ack}, 32'h0);
		sack_n <= 1'b0;
		up(IDX_SACK, 4'h0);
		sack_n <= 1'b1;
		up(IDX_SACK, 4'h1);
	endtask

	task automatic t_resets;
		@(posedge ref_clk);
		espi_rstn <= 1'b0;
		tick(6);
		espi_rstn <= 1'b1;
		tick(10);
		#1;
		check({29'h0, sleep}, 32'h0);
		up(IDX_BOOT, 4'h9);
		cfg(1'b0, LOC_CH0, 32'h0, 32'h00001113);
		cfg(1'b0, LOC_CH1, 32'h0, 32'h00003F00);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// main sequence, reset held for 8 cycles
	initial begin
		mismatches = 0;
		total_checks = 0;
		rstn = 1'b0;
		espi_rstn = 1'b0;
		plt_rstn = 1'b0;
		role = 1'b0;
		sack_n = 1'b1;
		halted = 1'b0;
		dn_valid = 1'b0;
		dn_idx = 8'h00;
		dn_data = 4'h0;
		cfg_req = 1'b0;
		cfg_wr = 1'b0;
		cfg_loc = 16'h0000;
		cfg_wdata = 32'h0;
		host_delay = 8'd0;
		tick(8);
		rstn <= 1'b1;
		espi_rstn <= 1'b1;
		plt_rstn <= 1'b1;
		tick(10);
		t_config;
		t_secondary;
		t_delayed_start;
		t_primary;
		t_resets;
		results;
	end

	// a hang counts as a mismatch
	initial begin
		tick(20000);
		mismatches++;
		results;
	end
endmodule
`default_nettype wire
